/* hw/smc_wait_pkg.sv */
// constants and types for the static memory wait, slow clock and page read block
package smc_wait_pkg;
   localparam int CS_W       = 3;
   localparam int ADDR_W     = 26;
   localparam int SETUP_W    = 6;
   localparam int PULSE_W    = 7;
   localparam int CYCLE_W    = 9;
   localparam int CNT_W      = 10;
   localparam int PAGE_HI    = 25;
   localparam int SYNC_DEPTH = 2;

   // external wait mode encodings
   localparam logic [1:0] WAIT_OFF    = 2'h0;
   localparam logic [1:0] WAIT_FROZEN = 2'h2;
   localparam logic [1:0] WAIT_READY  = 2'h3;

   // page size encodings: 4, 8, 16, 32 bytes
   localparam logic [1:0] PAGE_4  = 2'h0;
   localparam logic [1:0] PAGE_8  = 2'h1;
   localparam logic [1:0] PAGE_16 = 2'h2;
   localparam logic [1:0] PAGE_32 = 2'h3;

   // data bus width encodings
   localparam logic [1:0] BUS_8  = 2'h0;
   localparam logic [1:0] BUS_16 = 2'h1;
   localparam logic [1:0] BUS_32 = 2'h2;

   // fixed slow clock waveforms, in cycles
   localparam logic [CNT_W-1:0] SLOW_RD_SETUP    = 10'h001;
   localparam logic [CNT_W-1:0] SLOW_RD_PULSE    = 10'h001;
   localparam logic [CNT_W-1:0] SLOW_CS_RD_SETUP = 10'h000;
   localparam logic [CNT_W-1:0] SLOW_CS_RD_PULSE = 10'h002;
   localparam logic [CNT_W-1:0] SLOW_RD_CYCLE    = 10'h002;
   localparam logic [CNT_W-1:0] SLOW_WR_SETUP    = 10'h001;
   localparam logic [CNT_W-1:0] SLOW_WR_PULSE    = 10'h001;
   localparam logic [CNT_W-1:0] SLOW_CS_WR_SETUP = 10'h000;
   localparam logic [CNT_W-1:0] SLOW_CS_WR_PULSE = 10'h003;
   localparam logic [CNT_W-1:0] SLOW_WR_CYCLE    = 10'h003;

   // reset values
   localparam logic [CNT_W-1:0]  CNT_RESET  = 10'h000;
   localparam logic [ADDR_W-1:0] ADDR_RESET = 26'h0000000;
   localparam logic [CS_W-1:0]   CS_RESET   = 3'h0;
   localparam logic [31:0]       DATA_RESET = 32'h00000000;
   localparam logic [SYNC_DEPTH-1:0] SYNC_RESET = 2'h3;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_RUN,
      ST_SUSPEND,
      ST_RELOAD
   } access_state_t;
endpackage

/* hw/wait_resync.sv */
// two-stage resynchroniser for the active-low wait input
`timescale 1ns/1ps
module wait_resync (
   input  wire logic sys_clk,
   input  wire logic arst_n,
   input  wire logic wait_request_n,
   output logic      wait_sync_n
);
   logic meta_reg;
   logic sync_reg;

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         meta_reg <= 1'b1;
         sync_reg <= 1'b1;
      end else begin
         meta_reg <= wait_request_n;
         sync_reg <= meta_reg;
      end
   end

   assign wait_sync_n = sync_reg;
endmodule // wait_resync

/* hw/static_mem_wait_slow_page_ctrl.sv */
// static memory access sequencer: external wait, slow clock waveforms, page reads
// Functional notes
// - wait is only sampled during the controlling strobe's pulse phase.
// - wait is active low and resynchronised before any decision uses it.
// - frozen mode: counters and all pin outputs hold while resynchronised wait is low.
// - ready mode: wait checked in last pulse cycle; suspend, then do hold.
// - ready mode: wait early release or late assertion leaves length unchanged.
// - wait mode 00 ignores the wait input completely.
// - slow clock indication replaces user waveforms with fixed ones on every chip select.
// - slow read: strobe setup 1 pulse 1, cs setup 0 pulse 2, cycle 2.
// - slow write: strobe setup 1 pulse 1, cs setup 0 pulse 3, cycle 3.
// - a transfer in progress on leaving slow mode finishes with slow timings.
// - entering or leaving slow mode inserts a reload wait state after the transfer.
// - page reads only with page enable; page size selects 4, 8, 16, 32 bytes.
// - page address is bits 25 down to log2 of page size.
// - offset ignores bit 0 for 16-bit, bits 1:0 for 32-bit devices.
// - in page mode read strobe and chip select stay low, identical timing.
// - first page access lasts cs read pulse, later ones read strobe pulse.
// - no coherency check; both pulse values are used as programmed.
// - byte access type still applies in page mode; software sets byte select.
// - same chip select and page address uses the short access time.
// - different page, chip select, or intervening access causes the long time.
`timescale 1ns/1ps
module static_mem_wait_slow_page_ctrl (
   input  wire logic                                sys_clk,
   input  wire logic                                arst_n,
   // access request from the internal bus
   input  wire logic                                req_valid,
   output logic                                     req_ready,
   input  wire logic                                req_write,
   input  wire logic [smc_wait_pkg::CS_W-1:0]       req_cs,
   input  wire logic [smc_wait_pkg::ADDR_W-1:0]     req_addr,
   input  wire logic [31:0]                         req_wdata,
   input  wire logic [3:0]                          req_byte_en,
   output logic                                     done_pulse,
   output logic [31:0]                              rd_data,
   // per-chip-select settings of the selected chip select, then slow clock and other access indications
   input  wire logic [smc_wait_pkg::SETUP_W-1:0]    read_strobe_setup,
   input  wire logic [smc_wait_pkg::PULSE_W-1:0]    read_strobe_pulse,
   input  wire logic [smc_wait_pkg::SETUP_W-1:0]    cs_read_setup,
   input  wire logic [smc_wait_pkg::PULSE_W-1:0]    cs_read_pulse,
   input  wire logic [smc_wait_pkg::CYCLE_W-1:0]    read_cycle_length,
   input  wire logic [smc_wait_pkg::SETUP_W-1:0]    write_strobe_setup,
   input  wire logic [smc_wait_pkg::PULSE_W-1:0]    write_strobe_pulse,
   input  wire logic [smc_wait_pkg::SETUP_W-1:0]    cs_write_setup,
   input  wire logic [smc_wait_pkg::PULSE_W-1:0]    cs_write_pulse,
   input  wire logic [smc_wait_pkg::CYCLE_W-1:0]    write_cycle_length,
   input  wire logic                                read_mode,
   input  wire logic                                write_mode,
   input  wire logic [1:0]                          external_wait_select,
   input  wire logic                                page_enable,
   input  wire logic [1:0]                          page_size_field,
   input  wire logic                                byte_access_type,
   input  wire logic [1:0]                          bus_width,
   input  wire logic                                slow_clock_active,
   input  wire logic                                other_access,
   // memory pins, then wait suspension and page hit status
   input  wire logic                                wait_request_n,
   output logic                                     chip_select_n,
   output logic [smc_wait_pkg::CS_W-1:0]            cs_index,
   output logic                                     read_strobe_n,
   output logic                                     write_strobe_n,
   output logic [3:0]                               byte_sel_n,
   output logic [smc_wait_pkg::ADDR_W-1:0]          mem_addr,
   output logic [31:0]                              mem_wdata,
   output logic                                     mem_wdata_oe,
   input  wire logic [31:0]                         mem_rdata,
   output logic                                     wait_suspended,
   output logic                                     page_hit
);
   logic                           suspend_go, rd_take;
   logic [smc_wait_pkg::CNT_W-1:0] pin_phase;

   smc_wait_pkg::access_state_t state_reg;
   logic                           wait_sync_n;
   logic [smc_wait_pkg::CNT_W-1:0] elapsed_reg;
   logic [smc_wait_pkg::CNT_W-1:0] st_setup_reg, st_pulse_reg, cs_setup_reg, cs_pulse_reg, cycle_reg;
   logic                           write_reg, ctrl_by_strobe_reg, page_acc_reg, slow_used_reg;
   logic [1:0]                     wait_mode_reg;
   logic                           slow_seen_reg;
   logic                           page_valid_reg;
   logic [smc_wait_pkg::CS_W-1:0]  page_cs_reg;
   logic [smc_wait_pkg::ADDR_W-1:0] page_addr_reg;
   logic                           start;
   logic                           in_ctrl_pulse, last_pulse, wait_low, freeze, finish;
   logic [smc_wait_pkg::CNT_W-1:0] ctrl_setup, ctrl_pulse;
   logic                           same_page;

   wait_resync u_wait_resync (
      .sys_clk        (sys_clk),
      .arst_n         (arst_n),
      .wait_request_n (wait_request_n),
      .wait_sync_n    (wait_sync_n)
   );

   // page address of an address for a given size code
   function automatic logic [smc_wait_pkg::ADDR_W-1:0] page_base(
      input logic [smc_wait_pkg::ADDR_W-1:0] a, input logic [1:0] ps);
      logic [smc_wait_pkg::ADDR_W-1:0] m;
      m = '1;
      case (ps)
         smc_wait_pkg::PAGE_4:  m[1:0] = 2'h0;
         smc_wait_pkg::PAGE_8:  m[2:0] = 3'h0;
         smc_wait_pkg::PAGE_16: m[3:0] = 4'h0;
         default:               m[4:0] = 5'h0;
      endcase
      return a & m;
   endfunction

   // widen a setup or pulse field to counter width
   function automatic logic [smc_wait_pkg::CNT_W-1:0] widen(input logic [8:0] v);
      return {1'b0, v};
   endfunction

   // offset drops low bits by width
   function automatic logic [smc_wait_pkg::ADDR_W-1:0] align_addr(
      input logic [smc_wait_pkg::ADDR_W-1:0] a, input logic [1:0] bw);
      case (bw)
         smc_wait_pkg::BUS_16: return {a[smc_wait_pkg::ADDR_W-1:1], 1'b0};
         smc_wait_pkg::BUS_32: return {a[smc_wait_pkg::ADDR_W-1:2], 2'h0};
         default:              return a;
      endcase
   endfunction

   // a pending slow mode change holds requests off until the reload cycle
   assign req_ready = ((state_reg == smc_wait_pkg::ST_IDLE) && (slow_clock_active == slow_seen_reg)) ||
                      (state_reg == smc_wait_pkg::ST_RELOAD);
   assign start     = req_valid && req_ready;

   // same cs and page is a hit
   assign same_page = page_valid_reg && !other_access && (page_cs_reg == req_cs) &&
                      (page_base(req_addr, page_size_field) == page_base(page_addr_reg, page_size_field));
   assign page_hit  = same_page;

   assign ctrl_setup    = ctrl_by_strobe_reg ? st_setup_reg : cs_setup_reg;
   assign ctrl_pulse    = ctrl_by_strobe_reg ? st_pulse_reg : cs_pulse_reg;
   // sample only in the pulse phase
   assign in_ctrl_pulse = (state_reg == smc_wait_pkg::ST_RUN) && !page_acc_reg &&
                          (elapsed_reg >= ctrl_setup) && (elapsed_reg < ctrl_setup + ctrl_pulse);
   assign last_pulse    = in_ctrl_pulse && (elapsed_reg == ctrl_setup + ctrl_pulse - 10'h001);
   assign wait_low      = !wait_sync_n;
   assign freeze        = (wait_mode_reg == smc_wait_pkg::WAIT_FROZEN) && in_ctrl_pulse && wait_low;
   assign finish        = (state_reg == smc_wait_pkg::ST_RUN) && !freeze &&
                          (elapsed_reg + 10'h001 >= cycle_reg);
   assign suspend_go    = (wait_mode_reg == smc_wait_pkg::WAIT_READY) && last_pulse && wait_low;
   assign pin_phase     = (state_reg == smc_wait_pkg::ST_SUSPEND) ? elapsed_reg : elapsed_reg + 10'h001;
   // read data is taken while the controlling strobe is still low
   assign rd_take       = !write_reg && ((last_pulse && !freeze && !suspend_go) ||
                          ((state_reg == smc_wait_pkg::ST_SUSPEND) && !wait_low) || (page_acc_reg && finish));

   // access sequencing
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg   <= smc_wait_pkg::ST_IDLE;
         elapsed_reg <= smc_wait_pkg::CNT_RESET;
      end else begin
         case (state_reg)
            smc_wait_pkg::ST_IDLE: begin
               elapsed_reg <= smc_wait_pkg::CNT_RESET;
               // reload state on slow mode change
               if (slow_clock_active != slow_seen_reg)
                  state_reg <= smc_wait_pkg::ST_RELOAD;
               else if (start)
                  state_reg <= smc_wait_pkg::ST_RUN;
            end
            smc_wait_pkg::ST_RUN: begin
               // ready mode checks last pulse cycle
               if (suspend_go) begin
                  state_reg   <= smc_wait_pkg::ST_SUSPEND;
                  elapsed_reg <= elapsed_reg + 10'h001;
               end else if (finish) begin
                  state_reg   <= smc_wait_pkg::ST_IDLE;
               end else if (!freeze) begin
                  elapsed_reg <= elapsed_reg + 10'h001;
               end
            end
            smc_wait_pkg::ST_SUSPEND: begin
               if (!wait_low)
                  state_reg <= (elapsed_reg >= cycle_reg) ? smc_wait_pkg::ST_IDLE : smc_wait_pkg::ST_RUN;
            end
            smc_wait_pkg::ST_RELOAD: state_reg <= start ? smc_wait_pkg::ST_RUN : smc_wait_pkg::ST_IDLE;
            default: state_reg <= smc_wait_pkg::ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n)
         slow_seen_reg <= 1'b0;
      else if (state_reg == smc_wait_pkg::ST_RELOAD)
         slow_seen_reg <= slow_clock_active;
   end

   // timing latched at start, so a slow mode change mid-transfer keeps the old set
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_setup_reg <= smc_wait_pkg::CNT_RESET;
         st_pulse_reg <= smc_wait_pkg::CNT_RESET;
         cs_setup_reg <= smc_wait_pkg::CNT_RESET;
         cs_pulse_reg <= smc_wait_pkg::CNT_RESET;
         cycle_reg    <= smc_wait_pkg::CNT_RESET;
         write_reg    <= 1'b0;
         ctrl_by_strobe_reg <= 1'b0;
         page_acc_reg <= 1'b0;
         slow_used_reg <= 1'b0;
         wait_mode_reg <= smc_wait_pkg::WAIT_OFF;
      end else if (start) begin
         write_reg     <= req_write;
         // slow set kept to the end
         slow_used_reg <= slow_clock_active;
         page_acc_reg  <= 1'b0;
         wait_mode_reg <= external_wait_select;
         if (slow_clock_active) begin
            st_setup_reg  <= req_write ? smc_wait_pkg::SLOW_WR_SETUP : smc_wait_pkg::SLOW_RD_SETUP;
            st_pulse_reg  <= req_write ? smc_wait_pkg::SLOW_WR_PULSE : smc_wait_pkg::SLOW_RD_PULSE;
            cs_setup_reg  <= req_write ? smc_wait_pkg::SLOW_CS_WR_SETUP : smc_wait_pkg::SLOW_CS_RD_SETUP;
            cs_pulse_reg  <= req_write ? smc_wait_pkg::SLOW_CS_WR_PULSE : smc_wait_pkg::SLOW_CS_RD_PULSE;
            cycle_reg     <= req_write ? smc_wait_pkg::SLOW_WR_CYCLE : smc_wait_pkg::SLOW_RD_CYCLE;
            ctrl_by_strobe_reg <= 1'b1;
            wait_mode_reg <= smc_wait_pkg::WAIT_OFF;
         end else if (!req_write && page_enable) begin
            // first access cs pulse, later strobe pulse
            page_acc_reg  <= 1'b1;
            st_setup_reg  <= smc_wait_pkg::CNT_RESET;
            cs_setup_reg  <= smc_wait_pkg::CNT_RESET;
            st_pulse_reg  <= same_page ? widen({2'h0, read_strobe_pulse}) : widen({2'h0, cs_read_pulse});
            cs_pulse_reg  <= same_page ? widen({2'h0, read_strobe_pulse}) : widen({2'h0, cs_read_pulse});
            cycle_reg     <= same_page ? widen({2'h0, read_strobe_pulse}) : widen({2'h0, cs_read_pulse});
            wait_mode_reg <= smc_wait_pkg::WAIT_OFF;
         end else if (req_write) begin
            st_setup_reg  <= widen({3'h0, write_strobe_setup});
            st_pulse_reg  <= widen({2'h0, write_strobe_pulse});
            cs_setup_reg  <= widen({3'h0, cs_write_setup});
            cs_pulse_reg  <= widen({2'h0, cs_write_pulse});
            cycle_reg     <= widen(write_cycle_length);
            ctrl_by_strobe_reg <= write_mode;
         end else begin
            st_setup_reg  <= widen({3'h0, read_strobe_setup});
            st_pulse_reg  <= widen({2'h0, read_strobe_pulse});
            cs_setup_reg  <= widen({3'h0, cs_read_setup});
            cs_pulse_reg  <= widen({2'h0, cs_read_pulse});
            cycle_reg     <= widen(read_cycle_length);
            ctrl_by_strobe_reg <= read_mode;
         end
      end
   end

   // page tracking
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         page_valid_reg <= 1'b0;
         page_cs_reg    <= smc_wait_pkg::CS_RESET;
         page_addr_reg  <= smc_wait_pkg::ADDR_RESET;
      end else if (start) begin
         page_valid_reg <= !req_write && page_enable && !slow_clock_active;
         page_cs_reg    <= req_cs;
         page_addr_reg  <= req_addr;
      end else if (other_access || (state_reg == smc_wait_pkg::ST_RELOAD)) begin
         page_valid_reg <= 1'b0;
      end
   end

   // address, data and select outputs, held through the whole access
   // suspension holds pulse levels
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         cs_index     <= smc_wait_pkg::CS_RESET;
         mem_addr     <= smc_wait_pkg::ADDR_RESET;
         mem_wdata    <= smc_wait_pkg::DATA_RESET;
         byte_sel_n   <= 4'hf;
         mem_wdata_oe <= 1'b0;
      end else if (start) begin
         cs_index     <= req_cs;
         mem_addr     <= align_addr(req_addr, bus_width);
         mem_wdata    <= req_wdata;
         // byte select kept in page mode
         byte_sel_n   <= byte_access_type ? 4'h0 : ~req_byte_en;
         mem_wdata_oe <= req_write;
      end else if (state_reg == smc_wait_pkg::ST_IDLE) begin
         mem_wdata_oe <= 1'b0;
      end
   end

   // strobes from flops; page mode keeps cs and read strobe low together
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         chip_select_n  <= 1'b1;
         read_strobe_n  <= 1'b1;
         write_strobe_n <= 1'b1;
      end else if ((state_reg == smc_wait_pkg::ST_RUN && !finish && !freeze && !suspend_go) ||
                   (state_reg == smc_wait_pkg::ST_SUSPEND && !wait_low)) begin
         // page mode cs and strobe low
         if (page_acc_reg) begin
            chip_select_n <= 1'b0;
            read_strobe_n <= 1'b0;
         end else begin
            chip_select_n  <= !((pin_phase >= cs_setup_reg) &&
                               (pin_phase < cs_setup_reg + cs_pulse_reg));
            read_strobe_n  <= write_reg || !((pin_phase >= st_setup_reg) &&
                               (pin_phase < st_setup_reg + st_pulse_reg));
            write_strobe_n <= !write_reg || !((pin_phase >= st_setup_reg) &&
                               (pin_phase < st_setup_reg + st_pulse_reg));
         end
      end else if (start) begin
         // phase 0 levels come from the new request, not from the latched set
         chip_select_n  <= !(slow_clock_active || (!req_write && page_enable) ||
                             (req_write ? cs_write_setup == 6'h00 : cs_read_setup == 6'h00));
         read_strobe_n  <= req_write || !(!slow_clock_active && (page_enable || read_strobe_setup == 6'h00));
         write_strobe_n <= !req_write || slow_clock_active || (write_strobe_setup != 6'h00);
      end else if (state_reg == smc_wait_pkg::ST_IDLE || finish) begin
         read_strobe_n  <= !(page_acc_reg && finish);
         write_strobe_n <= 1'b1;
         chip_select_n  <= page_acc_reg && finish ? 1'b0 : 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         done_pulse     <= 1'b0;
         rd_data        <= smc_wait_pkg::DATA_RESET;
         wait_suspended <= 1'b0;
      end else begin
         done_pulse     <= finish;
         wait_suspended <= ((state_reg == smc_wait_pkg::ST_SUSPEND) && wait_low) || freeze;
         if (rd_take)
            rd_data <= mem_rdata;
      end
   end
endmodule // static_mem_wait_slow_page_ctrl

/* tb/smc_wait_monitor.sv */
// pin level checks for the static memory access sequencer
`timescale 1ns/1ps
module smc_wait_monitor (
   input wire logic       sys_clk,
   input wire logic       arst_n,
   input wire logic       done_pulse,
   input wire logic [1:0] external_wait_select,
   input wire logic       page_enable,
   input wire logic       slow_clock_active,
   input wire logic       other_access,
   input wire logic       wait_request_n,
   input wire logic       chip_select_n,
   input wire logic       read_strobe_n,
   input wire logic       write_strobe_n,
   input wire logic       mem_wdata_oe,
   input wire logic       wait_suspended,
   input wire logic       page_hit
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   sequence s_rd_fall; slow_clock_active && $fell(read_strobe_n); endsequence
   sequence s_wr_fall; slow_clock_active && $fell(write_strobe_n); endsequence
   property p_done_one; done_pulse |=> !done_pulse; endproperty
   a_done_one: assert property (p_done_one) else $error("done pulse too long");
   property p_slow_rd; s_rd_fall |=> $rose(read_strobe_n); endproperty
   a_slow_rd: assert property (p_slow_rd) else $error("slow read pulse not one cycle");
   property p_slow_wr; s_wr_fall |=> $rose(write_strobe_n); endproperty
   a_slow_wr: assert property (p_slow_wr) else $error("slow write pulse not one cycle");
   property p_resync; $fell(wait_request_n) |=> !$rose(wait_suspended); endproperty
   a_resync: assert property (p_resync) else $error("wait acted on before resync");
   property p_pulse_only; wait_suspended |-> !read_strobe_n || !write_strobe_n || !chip_select_n; endproperty
   a_pulse_only: assert property (p_pulse_only) else $error("suspended outside pulse");
   property p_off; external_wait_select == smc_wait_pkg::WAIT_OFF |-> !wait_suspended; endproperty
   a_off: assert property (p_off) else $error("suspended with wait off");
   property p_hold; wait_suspended ##1 wait_suspended |-> $stable({chip_select_n, read_strobe_n, write_strobe_n});
   endproperty
   a_hold: assert property (p_hold) else $error("pins moved while suspended");
   property p_page_same; page_enable && write_strobe_n && !mem_wdata_oe |-> read_strobe_n == chip_select_n;
   endproperty
   a_page_same: assert property (p_page_same) else $error("page strobe and select differ");
   property p_break; other_access |-> !page_hit; endproperty
   a_break: assert property (p_break) else $error("page hit across other access");
endmodule // smc_wait_monitor

/* tb/mem_device_model.sv */
// static memory that can stretch an access through its wait line
`timescale 1ns/1ps
module mem_device_model (
   input  wire logic        sys_clk,
   input  wire logic        chip_select_n,
   input  wire logic        read_strobe_n,
   input  wire logic        write_strobe_n,
   input  wire logic [25:0] mem_addr,
   input  wire logic [31:0] mem_wdata,
   input  wire logic [3:0]  stall_len,
   output logic [31:0]      mem_rdata,
   output logic             wait_request_n
);
   logic [31:0] store_reg [16];
   logic [31:0] last_reg = 32'h0;
   logic        strb_reg = 1'h1;
   int          stall_cnt = 0;
   initial for (int i = 0; i < 16; i++) store_reg[i] = 32'h5a5a5a5a ^ i;
   always @(posedge sys_clk) begin
      strb_reg <= read_strobe_n & write_strobe_n;
      if (!chip_select_n && !write_strobe_n) store_reg[mem_addr[5:2]] <= mem_wdata;
      if (!chip_select_n && !read_strobe_n) last_reg <= store_reg[mem_addr[5:2]];
      if (stall_cnt > 0) stall_cnt <= stall_cnt - 1;
      else if (strb_reg && !(read_strobe_n & write_strobe_n)) stall_cnt <= int'(stall_len);
   end
   assign wait_request_n = (stall_cnt == 0);
   // released bus shows inverted last value, never a stale match
   assign mem_rdata = (!chip_select_n && !read_strobe_n) ? store_reg[mem_addr[5:2]] : ~last_reg;
endmodule // mem_device_model

/* tb/static_mem_wait_slow_page_ctrl_bench.sv */
// self-checking bench for the static memory access sequencer
`timescale 1ns/1ps
module static_mem_wait_slow_page_ctrl_bench;
   logic        sys_clk = 1'h0, arst_n = 1'h0, req_valid = 1'h0, req_write = 1'h0, other_access = 1'h0;
   logic        page_enable = 1'h0, slow_clock_active = 1'h0, req_ready, done_pulse, wait_request_n;
   logic        chip_select_n, read_strobe_n, write_strobe_n;
   logic [1:0]  external_wait_select = 2'h0, page_size_field = 2'h0;
   logic [3:0]  stall_len = 4'h0;
   logic [25:0] req_addr = 26'h0, mem_addr;
   logic [31:0] req_wdata = 32'h0, rd_data, mem_rdata, mem_wdata, len;
   logic [5:0]  read_strobe_setup = 6'h01, cs_read_setup = 6'h00, write_strobe_setup = 6'h01, cs_write_setup = 6'h00;
   logic [6:0]  read_strobe_pulse = 7'h02, cs_read_pulse = 7'h04, write_strobe_pulse = 7'h02, cs_write_pulse = 7'h04;
   logic [8:0]  read_cycle_length = 9'h004, write_cycle_length = 9'h004;
   int          num_errors = 0, n_compared = 0, cycles = 0;
   static_mem_wait_slow_page_ctrl dut (.sys_clk, .arst_n, .req_valid, .req_ready, .req_write, .req_cs(3'h1),
      .req_addr, .req_wdata, .req_byte_en(4'hf), .done_pulse, .rd_data, .read_strobe_setup, .read_strobe_pulse,
      .cs_read_setup, .cs_read_pulse, .read_cycle_length, .write_strobe_setup, .write_strobe_pulse, .cs_write_setup,
      .cs_write_pulse, .write_cycle_length, .read_mode(1'h1), .write_mode(1'h1), .external_wait_select,
      .page_enable, .page_size_field, .byte_access_type(1'h0), .bus_width(smc_wait_pkg::BUS_32),
      .slow_clock_active, .other_access, .wait_request_n, .chip_select_n, .cs_index(), .read_strobe_n,
      .write_strobe_n, .byte_sel_n(), .mem_addr, .mem_wdata, .mem_wdata_oe(), .mem_rdata, .wait_suspended(),
      .page_hit());
   mem_device_model mem (.sys_clk, .chip_select_n, .read_strobe_n, .write_strobe_n, .mem_addr, .mem_wdata,
      .stall_len, .mem_rdata, .wait_request_n);
   initial forever #20 sys_clk = ~sys_clk;
   task automatic summarize();
      $display("compared %0d errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 5000) begin
         num_errors++;
         summarize();
      end
   end
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   // one access: cycles from raising the request to the done pulse
   task automatic acc(input logic w, input logic [25:0] a, input logic [31:0] d);
      logic r;
      req_valid = 1'h1;
      req_write = w;
      req_addr = a;
      req_wdata = d;
      len = 32'h0;
      do begin
         @(negedge sys_clk) r = req_ready;
         @(posedge sys_clk);
         len++;
      end while (r !== 1'h1 && len < 300);
      #1 req_valid = 1'h0;
      do begin
         @(posedge sys_clk);
         len++;
         @(negedge sys_clk);
      end while (done_pulse !== 1'h1 && len < 300);
      @(posedge sys_clk);
      #1;
   endtask
   task automatic acc_len(input logic w, input logic [25:0] a, input logic [31:0] exp);
      acc(w, a, 32'hc3a50f1e ^ a);
      check("access length", exp, len);
   endtask
   initial begin
      repeat (10) @(posedge sys_clk);
      #1 arst_n = 1'h1;
      stall_len = 4'h6;
      acc_len(1'h1, 26'h10, 32'h5);
      acc_len(1'h0, 26'h10, 32'h5);
      check("rd_data", 32'hc3a50f1e ^ 32'h10, rd_data);
      {read_strobe_pulse, write_strobe_pulse, cs_read_pulse, cs_write_pulse} = {7'h06, 7'h06, 7'h07, 7'h07};
      {read_cycle_length, write_cycle_length} = {9'h8, 9'h8};
      external_wait_select = smc_wait_pkg::WAIT_READY;
      stall_len = 4'h2;
      acc_len(1'h0, 26'h10, 32'h9);
      stall_len = 4'h8;
      acc(1'h1, 26'h14, 32'h0);
      check("ready stretch", 32'h1, {31'h0, len > 32'h9});
      external_wait_select = smc_wait_pkg::WAIT_FROZEN;
      acc(1'h0, 26'h14, 32'h0);
      check("frozen stretch", 32'h1, {31'h0, len > 32'h9});
      check("rd_data", 32'h0, rd_data);
      external_wait_select = smc_wait_pkg::WAIT_OFF;
      stall_len = 4'h0;
      slow_clock_active = 1'h1;
      acc_len(1'h0, 26'h10, 32'h4);
      acc_len(1'h0, 26'h10, 32'h3);
      acc_len(1'h1, 26'h18, 32'h4);
      slow_clock_active = 1'h0;
      acc_len(1'h0, 26'h18, 32'h a);
      page_enable = 1'h1;
      cs_read_pulse = 7'h05;
      read_strobe_pulse = 7'h02;
      for (int ps = 0; ps < 4; ps++) begin
         page_size_field = ps[1:0];
         acc_len(1'h0, 26'((ps + 1) << 6), 32'h6);
         acc_len(1'h0, 26'(((ps + 1) << 6) + (4 << ps) - 1), 32'h3);
         acc_len(1'h0, 26'(((ps + 1) << 6) + (4 << ps)), 32'h6);
      end
      other_access = 1'h1;
      @(posedge sys_clk);
      #1 other_access = 1'h0;
      acc_len(1'h0, 26'h120, 32'h6);
      cs_read_pulse = 7'h01;
      read_strobe_pulse = 7'h03;
      acc_len(1'h0, 26'h200, 32'h2);
      acc_len(1'h0, 26'h201, 32'h4);
      summarize();
   end
endmodule // static_mem_wait_slow_page_ctrl_bench
bind static_mem_wait_slow_page_ctrl smc_wait_monitor mon (.sys_clk, .arst_n, .done_pulse, .external_wait_select,
   .page_enable, .slow_clock_active, .other_access, .wait_request_n, .chip_select_n, .read_strobe_n,
   .write_strobe_n, .mem_wdata_oe, .wait_suspended, .page_hit);
